// file: design/vcr_map.vh
// register map, field layout and coding constants of the channel control bank
`ifndef VCR_MAP_VH
`define VCR_MAP_VH

// ----------------------------------------
// bus address and sub-addresses
// ----------------------------------------
`define VCR_ADDR_FIXED 5'h0b
`define VCR_SUB_CH1 8'h01
`define VCR_SUB_CH2 8'h02
`define VCR_SUB_CH3 8'h03
`define VCR_BIT_LAST 3'h7
`define VCR_BIT_FIRST 3'h0

// ----------------------------------------
// channel register fields
// ----------------------------------------
`define VCR_CTRL_RST 8'h00
`define VCR_F_CLAMP 7:6
`define VCR_F_MUX 5
`define VCR_F_LPF 4:3
`define VCR_F_BIAS 2:0

// ----------------------------------------
// field codes
// ----------------------------------------
`define VCR_BIAS_OFF 3'h0
`define VCR_BIAS_MUTE 3'h1
`define VCR_BIAS_DC 3'h2
`define VCR_BIAS_DC_OFS 3'h3
`define VCR_BIAS_AC 3'h4
`define VCR_BIAS_STC_LOW 3'h5
`define VCR_CLAMP_500K 2'h0
`define VCR_CLAMP_2M5 2'h1
`define VCR_CLAMP_5M 2'h2
`define VCR_SINK_NONE 2'h0

// ----------------------------------------
// synchroniser reset levels: scl, sda idle high, select pins low
// ----------------------------------------
`define VCR_SYNC_RST 4'h3

`endif

// file: design/vcr_regs.v
// serial-port slave and three channel control registers with field decode
`include "vcr_map.vh"
`timescale 1ns/1ps
`default_nettype none

module vcr_regs (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// serial bus pins, sda open drain
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	// address select pins
	input wire addr_select_high_pin_i,
	input wire addr_select_low_pin_i,
	// per-channel controls, channel one in the lowest bits
	output reg [2:0] chan_power_o,
	output reg [2:0] chan_mute_o,
	output reg [2:0] chan_input_b_o,
	output reg [5:0] video_lowpass_o,
	output reg [2:0] chan_dc_bias_o,
	output reg [2:0] chan_dc_offset_o,
	output reg [2:0] chan_ac_bias_o,
	output reg [2:0] sync_tip_clamp_o,
	output reg [5:0] sync_tip_clamp_sink_o,
	output reg [5:0] sync_tip_clamp_filter_o
);

localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_ADDR = 4'h1;
localparam [3:0] ST_ACK_A = 4'h2;
localparam [3:0] ST_SUB = 4'h3;
localparam [3:0] ST_ACK_S = 4'h4;
localparam [3:0] ST_DATA = 4'h5;
localparam [3:0] ST_ACK_D = 4'h6;
localparam [3:0] ST_RD = 4'h7;
localparam [3:0] ST_IGNORE = 4'h8;

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
wire [3:0] pins_s;
wire scl_s;
wire sda_s;
wire sel_hi_s;
wire sel_lo_s;

vcr_sync #(.W(4), .RST_VAL(`VCR_SYNC_RST)) u_sync (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.async_i({addr_select_high_pin_i, addr_select_low_pin_i, scl_i, sda_i}),
	.level_o(pins_s)
);

assign sel_hi_s = pins_s[3];
assign sel_lo_s = pins_s[2];
assign scl_s = pins_s[1];
assign sda_s = pins_s[0];

// ----------------------------------------
// bus condition detect
// ----------------------------------------
reg scl_prev_q;
reg sda_prev_q;
wire scl_rise;
wire scl_fall;
wire bus_start;
wire bus_stop;

assign scl_rise = scl_s & ~scl_prev_q;
assign scl_fall = ~scl_s & scl_prev_q;
assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

always @(posedge ref_clk_i or posedge rst_i) begin
	if (rst_i) begin
		scl_prev_q <= 1'b1;
		sda_prev_q <= 1'b1;
	end else begin
		scl_prev_q <= scl_s;
		sda_prev_q <= sda_s;
	end
end

// ----------------------------------------
// transfer state machine
// ----------------------------------------
reg [3:0] state_q;
reg [2:0] bit_cnt_q;
reg [6:0] shift_q;
reg [7:0] sub_q;
reg [7:0] tx_q;
reg ack_on_q;
reg [23:0] chan_q;
reg [7:0] rd_byte;
wire [7:0] rx_byte;
wire byte_done;
wire addr_hit;

assign rx_byte = {shift_q, sda_s};
assign byte_done = scl_rise & (bit_cnt_q == `VCR_BIT_LAST);
assign addr_hit = shift_q == {`VCR_ADDR_FIXED, sel_hi_s, sel_lo_s};

// selected register for a read, zero for an undefined sub-address
always @* begin
	case (sub_q)
	`VCR_SUB_CH1: rd_byte = chan_q[7:0];
	`VCR_SUB_CH2: rd_byte = chan_q[15:8];
	`VCR_SUB_CH3: rd_byte = chan_q[23:16];
	default: rd_byte = `VCR_CTRL_RST;
	endcase
end

always @(posedge ref_clk_i or posedge rst_i) begin
	if (rst_i) begin
		state_q <= ST_IDLE;
		bit_cnt_q <= `VCR_BIT_FIRST;
		shift_q <= 7'h00;
		sub_q <= 8'h00;
		tx_q <= 8'h00;
		ack_on_q <= 1'b0;
		sda_o <= 1'b0;
		sda_oe_o <= 1'b0;
		chan_q <= 24'h00_0000;
	end else if (bus_start) begin
		// repeated start also lands here
		state_q <= ST_ADDR;
		bit_cnt_q <= `VCR_BIT_FIRST;
		ack_on_q <= 1'b0;
		sda_oe_o <= 1'b0;
	end else if (bus_stop) begin
		state_q <= ST_IDLE;
		ack_on_q <= 1'b0;
		sda_oe_o <= 1'b0;
	end else begin
		if (scl_rise) begin
			shift_q <= rx_byte[6:0];
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
		case (state_q)
		ST_ADDR: begin
			if (byte_done) begin
				tx_q <= {7'h00, sda_s};
				state_q <= addr_hit ? ST_ACK_A : ST_IGNORE;
			end
		end
		ST_SUB: begin
			if (byte_done) begin
				sub_q <= rx_byte;
				state_q <= ST_ACK_S;
			end
		end
		ST_DATA: begin
			if (byte_done) begin
				state_q <= ST_ACK_D;
				case (sub_q)
				`VCR_SUB_CH1: chan_q[7:0] <= rx_byte;
				`VCR_SUB_CH2: chan_q[15:8] <= rx_byte;
				`VCR_SUB_CH3: chan_q[23:16] <= rx_byte;
				default: chan_q <= chan_q;
				endcase
			end
		end
		ST_ACK_A, ST_ACK_S, ST_ACK_D: begin
			// drive low after the byte; on the next falling edge release, or after a read address drive the first read bit
			if (scl_fall) begin
				if (!ack_on_q) begin
					ack_on_q <= 1'b1;
					sda_oe_o <= 1'b1;
				end else begin
					ack_on_q <= 1'b0;
					sda_oe_o <= 1'b0;
					bit_cnt_q <= `VCR_BIT_FIRST;
					if (state_q == ST_ACK_S) begin
						state_q <= ST_DATA;
					end else if (state_q == ST_ACK_D) begin
						state_q <= ST_IGNORE;
					end else if (tx_q[0]) begin
						tx_q <= rd_byte;
						sda_oe_o <= ~rd_byte[7];
						state_q <= ST_RD;
					end else begin
						state_q <= ST_SUB;
					end
				end
			end
		end
		ST_RD: begin
			if (scl_rise) begin
				tx_q <= {tx_q[6:0], 1'b0};
				if (bit_cnt_q == `VCR_BIT_LAST) begin
					state_q <= ST_IGNORE;
				end
			end else if (scl_fall) begin
				sda_oe_o <= ~tx_q[7];
			end
		end
		ST_IGNORE: begin
			// bytes past the single data byte get no ack
			if (scl_fall) begin
				sda_oe_o <= 1'b0;
			end
		end
		ST_IDLE: begin
			sda_oe_o <= 1'b0;
		end
		default: begin
			state_q <= ST_IDLE;
			sda_oe_o <= 1'b0;
		end
		endcase
	end
end

// ----------------------------------------
// channel field decode
// ----------------------------------------
genvar g;
wire [2:0] power_d;
wire [2:0] mute_d;
wire [2:0] input_b_d;
wire [5:0] lowpass_d;
wire [2:0] dc_bias_d;
wire [2:0] dc_offset_d;
wire [2:0] ac_bias_d;
wire [2:0] clamp_d;
wire [5:0] sink_d;
wire [5:0] filter_d;

// one decode slice per channel, channel one in the lowest bits
generate
for (g = 0; g < 3; g = g + 1) begin : g_chan
	wire [7:0] ctl;
	wire [2:0] bias;
	wire [1:0] fsel;
	assign ctl = chan_q[g*8 +: 8];
	assign bias = ctl[`VCR_F_BIAS];
	assign fsel = ctl[`VCR_F_CLAMP];
	assign power_d[g] = bias != `VCR_BIAS_OFF;
	assign mute_d[g] = bias == `VCR_BIAS_MUTE;
	assign input_b_d[g] = ctl[`VCR_F_MUX];
	assign lowpass_d[g*2 +: 2] = ctl[`VCR_F_LPF];
	assign dc_bias_d[g] = bias == `VCR_BIAS_DC;
	assign dc_offset_d[g] = bias == `VCR_BIAS_DC_OFS;
	assign ac_bias_d[g] = bias == `VCR_BIAS_AC;
	assign clamp_d[g] = bias >= `VCR_BIAS_STC_LOW;
	// low, mid, high sink follow the two low bias bits
	assign sink_d[g*2 +: 2] = clamp_d[g] ? bias[1:0] :
		`VCR_SINK_NONE;
	// filter forced to its idle code outside sync-tip clamping
	assign filter_d[g*2 +: 2] = !clamp_d[g] ? `VCR_CLAMP_500K :
		fsel[1] ? `VCR_CLAMP_5M :
		fsel[0] ? `VCR_CLAMP_2M5 : `VCR_CLAMP_500K;
end
endgenerate

always @(posedge ref_clk_i or posedge rst_i) begin
	if (rst_i) begin
		chan_power_o <= 3'h0;
		chan_mute_o <= 3'h0;
		chan_input_b_o <= 3'h0;
		video_lowpass_o <= 6'h00;
		chan_dc_bias_o <= 3'h0;
		chan_dc_offset_o <= 3'h0;
		chan_ac_bias_o <= 3'h0;
		sync_tip_clamp_o <= 3'h0;
		sync_tip_clamp_sink_o <= 6'h00;
		sync_tip_clamp_filter_o <= 6'h00;
	end else begin
		chan_power_o <= power_d;
		chan_mute_o <= mute_d;
		chan_input_b_o <= input_b_d;
		video_lowpass_o <= lowpass_d;
		chan_dc_bias_o <= dc_bias_d;
		chan_dc_offset_o <= dc_offset_d;
		chan_ac_bias_o <= ac_bias_d;
		sync_tip_clamp_o <= clamp_d;
		sync_tip_clamp_sink_o <= sink_d;
		sync_tip_clamp_filter_o <= filter_d;
	end
end

endmodule // vcr_regs

`default_nettype wire

// file: design/vcr_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module vcr_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// asynchronous level in, filtered level out
	input wire [W-1:0] async_i,
	output reg [W-1:0] level_o
);

reg [W-1:0] s1_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;
wire [W-1:0] agree;

// a bit moves only when the second and third stages agree
assign agree = ~(s2_q ^ s3_q);

always @(posedge ref_clk_i or posedge rst_i) begin
	if (rst_i) begin
		s1_q <= RST_VAL;
		s2_q <= RST_VAL;
		s3_q <= RST_VAL;
		level_o <= RST_VAL;
	end else begin
		s1_q <= async_i;
		s2_q <= s1_q;
		s3_q <= s2_q;
		level_o <= (agree & s3_q) | (~agree & level_o);
	end
end

endmodule // vcr_sync

`default_nettype wire

// file: tb/tb.sv
// testbench of the channel control bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic a1 = 1'b0;
	logic a0 = 1'b0;
	wire scl, low, oe, so;
	wire sda = ~(oe | low);
	wire [2:0] pw, mu, ib, dc, of, ac, st;
	wire [5:0] lp, sk, fl;
	wire [39:0] snap = {oe, pw, mu, ib, dc, of, ac, st, lp, sk, fl};
	int n_errors = 0;
	int check_count = 0;
	logic [2:0] k;
	logic [10:0] q;
	logic [39:0] s0;
	logic [7:0] v [9] = '{8'h00, 8'h21, 8'h4a, 8'hdb, 8'h0c, 8'hf5, 8'h9e,
		8'h6d, 8'hc7};
	vcr_regs vcr_regs_i (.ref_clk_i, .rst_i, .scl_i(scl), .sda_i(sda),
		.sda_o(so), .sda_oe_o(oe), .addr_select_high_pin_i(a1),
		.addr_select_low_pin_i(a0), .chan_power_o(pw), .chan_mute_o(mu),
		.chan_input_b_o(ib), .video_lowpass_o(lp), .chan_dc_bias_o(dc),
		.chan_dc_offset_o(of), .chan_ac_bias_o(ac), .sync_tip_clamp_o(st),
		.sync_tip_clamp_sink_o(sk), .sync_tip_clamp_filter_o(fl));
	vcr_i2c_master vcr_i2c_master_i (.scl_o(scl), .sda_low_o(low), .sda_i(sda));
	function automatic logic [12:0] ev(input logic [7:0] d);
		logic s;
		s = d[2] & (d[1] | d[0]);
		return {d[2:0] != 3'h0, d[2:0] == 3'h1, d[5], d[4:3], d[2:0] == 3'h2,
			d[2:0] == 3'h3, d[2:0] == 3'h4, s, s ? d[1:0] : 2'h0,
			s ? (d[7] ? 2'h2 : d[7:6]) : 2'h0};
	endfunction
	function automatic logic [12:0] act(input int c);
		return {pw[c], mu[c], ib[c], lp[2*c+:2], dc[c], of[c], ac[c], st[c],
			sk[2*c+:2], fl[2*c+:2]};
	endfunction
	function automatic logic [7:0] adr;
		return {5'h0b, a1, a0, 1'b0};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic t_regs;
		chk({so, snap}, 41'h0);
		for (int i = 0; i < 9; i++) begin
			vcr_i2c_master_i.wr(adr(), 8'(i % 3 + 1), v[i], k);
			chk(k, 3'h0);
			chk(act(i % 3), ev(v[i]));
			vcr_i2c_master_i.rd(adr(), 8'(i % 3 + 1), q);
			chk(q, {3'h0, v[i]});
		end
		$display("regs done");
	endtask
	task automatic t_bad;
		s0 = snap;
		vcr_i2c_master_i.wr(adr(), 8'h00, 8'hff, k);
		chk(k, 3'h0);
		vcr_i2c_master_i.wr(adr(), 8'h04, 8'hff, k);
		vcr_i2c_master_i.rd(adr(), 8'h04, q);
		chk({q, snap}, {11'h0, s0});
		$display("bad sub done");
	endtask
	task automatic t_addr;
		@(negedge ref_clk_i);
		a1 = 1'b1;
		a0 = 1'b1;
		vcr_i2c_master_i.wr(8'h58, 8'h01, 8'hff, k);
		chk({k, snap}, {3'h7, s0});
		vcr_i2c_master_i.wr(adr(), 8'h01, 8'h07, k);
		chk({k, act(0)}, {3'h0, ev(8'h07)});
		$display("address done");
	endtask
	task automatic t_burst;
		vcr_i2c_master_i.edge_x(1'b0);
		vcr_i2c_master_i.tx(adr(), k[2]);
		vcr_i2c_master_i.tx(8'h02, k[1]);
		vcr_i2c_master_i.tx(8'h21, k[0]);
		vcr_i2c_master_i.tx(8'hf5, q[0]);
		vcr_i2c_master_i.edge_x(1'b1);
		chk({k, q[0], act(1)}, {4'h1, ev(8'h21)});
		$display("burst done");
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#200_000;
		n_errors++;
		complete_run();
	end
	initial begin
		repeat (3) @(negedge ref_clk_i);
		rst_i = 1'b0;
		repeat (10) @(negedge ref_clk_i);
		t_regs();
		t_bad();
		t_addr();
		t_burst();
		complete_run();
	end
endmodule // tb
`default_nettype wire

// file: tb/vcr_i2c_master.sv
// serial bus master model
`timescale 1ns/1ps
`default_nettype none
module vcr_i2c_master (
	// bus lines, sda as pull-down enable
	output logic scl_o = 1'b1,
	output logic sda_low_o = 1'b0,
	input wire logic sda_i
);
	// data set mid-low, sampled at end of high
	task automatic bit_x(input logic v, output logic r);
		#40 sda_low_o = ~v;
		#40 scl_o = 1'b1;
		#80 r = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic edge_x(input logic p);
		#40 sda_low_o = p;
		#40 scl_o = 1'b1;
		#80 sda_low_o = ~p;
		#80 scl_o = p;
	endtask
	task automatic tx(input logic [7:0] d, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, nak);
	endtask
	task automatic wr(input logic [7:0] a, s, d, output logic [2:0] k);
		edge_x(1'b0);
		tx(a, k[2]);
		tx(s, k[1]);
		tx(d, k[0]);
		edge_x(1'b1);
	endtask
	task automatic rd(input logic [7:0] a, s, output logic [10:0] q);
		logic r;
		edge_x(1'b0);
		tx(a, q[10]);
		tx(s, q[9]);
		edge_x(1'b1);
		edge_x(1'b0);
		tx(a | 8'h01, q[8]);
		for (int i = 7; i >= 0; i--) bit_x(1'b1, q[i]);
		bit_x(1'b1, r);
		edge_x(1'b1);
	endtask
endmodule // vcr_i2c_master
`default_nettype wire

// file: tb/vcr_regs_props.sv
// port assertions of the channel control bank
`timescale 1ns/1ps
`default_nettype none
module vcr_regs_props (
	// clock, reset, bus
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// channel decode
	input wire logic [2:0] chan_power_o,
	input wire logic [2:0] chan_mute_o,
	input wire logic [2:0] sync_tip_clamp_o,
	input wire logic [5:0] sync_tip_clamp_sink_o,
	input wire logic [5:0] sync_tip_clamp_filter_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	wire [2:0] st = sync_tip_clamp_o;
	wire [5:0] sk = sync_tip_clamp_sink_o;
	wire [5:0] fl = sync_tip_clamp_filter_o;
	wire [5:0] st2 = {{2{st[2]}}, {2{st[1]}}, {2{st[0]}}};
	AST_SDA_LOW:
	assert property (sda_o == 1'b0) else $error("sda data high");
	AST_MUTE_ON:
	assert property ((chan_mute_o & ~chan_power_o) == 3'h0) else $error("mute");
	AST_CLAMP_ON:
	assert property ((st & ~chan_power_o) == 3'h0) else $error("clamp off");
	AST_CLAMP_IGNORED:
	assert property ((fl & ~st2) == 6'h0) else $error("filter");
	AST_SINK:
	assert property ({|sk[5:4], |sk[3:2], |sk[1:0]} == st) else $error("sink");
	AST_FILT_CODE:
	assert property ((fl[5:1] & fl[4:0] & 5'h15) == 5'h0) else $error("code");
	AST_OE_SCL_LOW:
	assert property ($changed(sda_oe_o) |-> !scl_i) else $error("oe moved");
	AST_ACK_HOLD:
	assert property ($rose(sda_oe_o) |-> sda_oe_o [*8]) else $error("oe short");
	AST_REG_AT_BIT:
	assert property ($changed(chan_power_o) |-> scl_i) else $error("reg moved");
endmodule // vcr_regs_props
bind vcr_regs vcr_regs_props vcr_regs_props_i (.ref_clk_i, .rst_i, .scl_i,
	.sda_o, .sda_oe_o, .chan_power_o, .chan_mute_o, .sync_tip_clamp_o,
	.sync_tip_clamp_sink_o, .sync_tip_clamp_filter_o);
`default_nettype wire
